// file: wiper_slave.sv
/*
 * Two-wire bus slave and wiper tap selection of a digital potentiometer.
 * Assumes the master drives the bus clock, the data line has an external
 * pull-up, and the straps are steady during a transfer.
 */
// Functional notes
// - Code zero selects tap at low terminal
// - Code 255 selects tap at high terminal
// - Tap follows wiper register only
// - Data sampled on bus clock rise
// - Transmit bits change after clock fall
// - Data line only pulled low, never driven
// - Straps give two low address bits
// - Mismatched address: transfer ignored
// - Id byte: fixed bits, straps, direction
// - Wiper resets to 80h
// - Acknowledge id, address, write data
// - Bytes travel most significant bit first
`timescale 1ns/1ps
`include "wiper_defs.svh"

module wiper_slave
    import wiper_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Address straps
    input  wire logic       address_strap_upper,
    input  wire logic       address_strap_lower,
    // Wiper outputs
    output logic [7:0]      tap_select,
    output logic            wiper_at_low_terminal,
    output logic            wiper_at_high_terminal
);

    // ------------------------------------------------------------
    // State storage
    // ------------------------------------------------------------
    slave_state_t s_reg;     // Registered state
    slave_state_t s_next;    // Next state

    logic scl_rise;          // Synced clock rose
    logic scl_fall;          // Synced clock fell
    logic start_seen;        // Start or repeated start
    logic stop_seen;         // Stop condition
    logic [7:0] rx_byte;     // Byte including current bit

    // ------------------------------------------------------------
    // Edge and condition detection, on second sync stage only
    // ------------------------------------------------------------
    assign scl_rise   = s_reg.scl_sync[1] & ~s_reg.scl_last;
    assign scl_fall   = ~s_reg.scl_sync[1] & s_reg.scl_last;
    assign start_seen = s_reg.scl_sync[1] & s_reg.scl_last & s_reg.sda_last & ~s_reg.sda_sync[1];
    assign stop_seen  = s_reg.scl_sync[1] & s_reg.scl_last & ~s_reg.sda_last & s_reg.sda_sync[1];
    assign rx_byte    = {s_reg.shift[6:0], s_reg.sda_sync[1]};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        // Synchronisers: first stage feeds only the second
        s_next.scl_sync = {s_reg.scl_sync[0], scl_in};
        s_next.sda_sync = {s_reg.sda_sync[0], sda_in};
        s_next.strap_s1 = {address_strap_upper, address_strap_lower};
        s_next.strap_s2 = s_reg.strap_s1;
        s_next.scl_last = s_reg.scl_sync[1];
        s_next.sda_last = s_reg.sda_sync[1];

        if (stop_seen)
        begin
            // Stop returns to standby and frees the line
            s_next.state  = ST_IDLE;
            s_next.sda_oe = 1'b0;
        end
        else if (start_seen)
        begin
            // Start, repeated or not, begins a new id byte
            s_next.state   = ST_ID;
            s_next.bit_cnt = 4'h0;
            s_next.sda_oe  = 1'b0;
        end
        else
        begin
            case (s_reg.state)
                ST_IDLE:
                begin
                    s_next.sda_oe = 1'b0;
                end
                ST_ID, ST_REGA, ST_WDAT:
                begin
                    if (scl_rise)
                    begin
                        s_next.shift   = rx_byte;
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end
                    // Eighth bit's falling edge: decide on acknowledge
                    if (scl_fall && s_reg.bit_cnt == 4'h8)
                    begin
                        s_next.bit_cnt   = 4'h0;
                        s_next.ack_drive = 1'b1;
                        s_next.rd_ack    = 1'b0;
                        s_next.state     = ST_ACK;
                        if (s_reg.state == ST_ID)
                        begin
                            if (s_reg.shift[7:1] == {`ID_UPPER_BITS, s_reg.strap_s2})
                            begin
                                s_next.sda_oe    = 1'b1;
                                s_next.after_ack = s_reg.shift[0] ? ST_RDAT : ST_REGA;
                            end
                            else
                            begin
                                // Not ours: stay off the line until next start
                                s_next.state = ST_IDLE;
                            end
                        end
                        else if (s_reg.state == ST_REGA)
                        begin
                            s_next.reg_ptr   = s_reg.shift;
                            s_next.sda_oe    = 1'b1;
                            s_next.after_ack = ST_WDAT;
                        end
                        else
                        begin
                            // Write data lands at the ninth clock
                            if (s_reg.reg_ptr == `WIPER_REG_ADDR)
                                s_next.wiper = s_reg.shift;
                            else if (s_reg.reg_ptr == `CONTROL_REG_ADDR)
                                s_next.control = s_reg.shift;
                            s_next.sda_oe    = 1'b1;
                            s_next.after_ack = ST_IDLE;
                        end
                    end
                end
                ST_ACK:
                begin
                    // Falling edge ends the ninth clock
                    if (scl_fall)
                    begin
                        if (s_reg.rd_ack)
                        begin
                            // Master nack ends the read
                            s_next.sda_oe = 1'b0;
                            s_next.state  = s_reg.shift[0] ? ST_IDLE : ST_RDAT;
                            if (!s_reg.shift[0])
                            begin
                                s_next.shift   = (s_reg.reg_ptr == `CONTROL_REG_ADDR) ? s_reg.control
                                                                                      : s_reg.wiper;
                                s_next.sda_oe  = ~s_next.shift[7];
                                s_next.bit_cnt = 4'h1;
                            end
                        end
                        else if (s_reg.after_ack == ST_RDAT)
                        begin
                            // First read bit right after the ack
                            s_next.shift   = (s_reg.reg_ptr == `CONTROL_REG_ADDR) ? s_reg.control
                                                                                  : s_reg.wiper;
                            s_next.sda_oe  = ~s_next.shift[7];
                            s_next.bit_cnt = 4'h1;
                            s_next.state   = ST_RDAT;
                        end
                        else
                        begin
                            s_next.sda_oe  = 1'b0;
                            s_next.bit_cnt = 4'h0;
                            s_next.state   = s_reg.after_ack;
                        end
                        s_next.ack_drive = 1'b0;
                    end
                    else if (s_reg.rd_ack && scl_rise)
                    begin
                        // Capture master's ack bit
                        s_next.shift[0] = s_reg.sda_sync[1];
                    end
                end
                ST_RDAT:
                begin
                    if (scl_fall)
                    begin
                        if (s_reg.bit_cnt == 4'h8)
                        begin
                            // Release for the master's ack
                            s_next.sda_oe = 1'b0;
                            s_next.rd_ack = 1'b1;
                            s_next.state  = ST_ACK;
                        end
                        else
                        begin
                            s_next.shift   = {s_reg.shift[6:0], 1'b0};
                            s_next.sda_oe  = ~s_reg.shift[6];
                            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                        end
                    end
                end
                default:
                begin
                    s_next.state  = ST_IDLE;
                    s_next.sda_oe = 1'b0;
                end
            endcase
        end

        // Tap selection follows the wiper code alone
        s_next.tap     = s_next.wiper;
        s_next.at_low  = (s_next.wiper == `TAP_LOW_END);
        s_next.at_high = (s_next.wiper == `TAP_HIGH_END);
    end

    // ------------------------------------------------------------
    // State register; reset presets wiper to mid-scale
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_reg           <= '0;
            s_reg.scl_sync  <= 2'h3;
            s_reg.sda_sync  <= 2'h3;
            s_reg.scl_last  <= 1'b1;
            s_reg.sda_last  <= 1'b1;
            s_reg.state     <= ST_IDLE;
            s_reg.after_ack <= ST_IDLE;
            s_reg.wiper     <= `WIPER_RESET_VAL;
            s_reg.tap       <= `WIPER_RESET_VAL;
            s_reg.control   <= `CONTROL_RESET_VAL;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from flip-flops except sda_out, which is tied low
    // ------------------------------------------------------------
    assign sda_out                = 1'b0;
    assign sda_oe                 = s_reg.sda_oe;
    assign tap_select             = s_reg.tap;
    assign wiper_at_low_terminal  = s_reg.at_low;
    assign wiper_at_high_terminal = s_reg.at_high;

endmodule // wiper_slave

// file: wiper_defs.svh
/*
 * Constants for the two-wire wiper position slave: identity bits,
 * register addresses, reset values and tap limits.
 * Assumes inclusion by bare name from the design file, the checker and the bench.
 */
`ifndef WIPER_DEFS_SVH
`define WIPER_DEFS_SVH

// ----------------------------------------------------------------
// Identification
// ----------------------------------------------------------------
// Upper five identification bits; value is arbitrary
`define ID_UPPER_BITS     5'h0B

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define WIPER_REG_ADDR    8'h00
`define CONTROL_REG_ADDR  8'h10
`define WIPER_RESET_VAL   8'h80
`define CONTROL_RESET_VAL 8'h42

// ----------------------------------------------------------------
// Tap limits
// ----------------------------------------------------------------
`define TAP_LOW_END       8'h00
`define TAP_HIGH_END      8'hFF

`endif

// file: wiper_pkg.sv
/*
 * Types for the two-wire wiper position slave.
 * Assumes the constants header is on the include path.
 */
package wiper_pkg;

    // ------------------------------------------------------------
    // Protocol states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,   // Waiting for a start
        ST_ID   = 6'h02,   // Receiving identification byte
        ST_REGA = 6'h04,   // Receiving register address
        ST_WDAT = 6'h08,   // Receiving write data
        ST_RDAT = 6'h10,   // Transmitting read data
        ST_ACK  = 6'h20    // Ninth clock of a byte
    } bus_state_t;

    // ------------------------------------------------------------
    // Whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] scl_sync;    // Clock synchroniser
        logic [1:0] sda_sync;    // Data synchroniser
        logic [1:0] strap_s1;    // Strap first stage
        logic [1:0] strap_s2;    // Strap second stage
        logic       scl_last;    // Previous synced clock
        logic       sda_last;    // Previous synced data
        bus_state_t state;       // Protocol state
        bus_state_t after_ack;   // State after ninth clock
        logic [3:0] bit_cnt;     // Bits taken in this byte
        logic [7:0] shift;       // Receive / transmit shifter
        logic [7:0] reg_ptr;     // Selected register
        logic [7:0] wiper;       // Wiper position code
        logic [7:0] control;     // Control register
        logic       ack_drive;   // Set at each received byte's eighth-bit fall, even on id mismatch
        logic       rd_ack;      // Ninth clock belongs to read byte
        logic       sda_oe;      // Pull data line low
        logic [7:0] tap;         // Selected tap
        logic       at_low;      // Wiper at low terminal
        logic       at_high;     // Wiper at high terminal
    } slave_state_t;

endpackage

// file: wiper_slave_assertions.sv
/* Concurrent checks on the wiper slave ports.
   Assumes a single clk domain and the constants header on the path. */
`timescale 1ns/1ps
`include "wiper_defs.svh"
module wiper_slave_checker
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Bus and strap pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       address_strap_upper,
    input wire logic       address_strap_lower,
    // Wiper outputs
    input wire logic [7:0] tap_select,
    input wire logic       wiper_at_low_terminal,
    input wire logic       wiper_at_high_terminal
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Open drain: the data pin is never driven high
    pull_low_only_a: assert property (sda_out == 1'b0)
        else $error("data pin value not low");
    low_end_flag_a: assert property ((tap_select == `TAP_LOW_END) == wiper_at_low_terminal)
        else $error("low end flag disagrees with tap");
    high_end_flag_a: assert property ((tap_select == `TAP_HIGH_END) == wiper_at_high_terminal)
        else $error("high end flag disagrees with tap");
    // A new tap only lands in the clock low phase after a byte
    tap_update_when_a: assert property ($changed(tap_select) |-> !scl_in)
        else $error("tap changed during clock high");
    reset_midscale_a: assert property ($fell(reset) |-> tap_select == `WIPER_RESET_VAL
        && !wiper_at_low_terminal && !wiper_at_high_terminal)
        else $error("tap not at mid scale after reset");
    ack_stands_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("pull-down dropped too early");
    oe_change_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data pin changed during clock high");
    oe_start_low_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("pull-down began outside a low phase");
    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    cover property ($rose(sda_oe));
    cover property (wiper_at_low_terminal);
    cover property (wiper_at_high_terminal);
endmodule // wiper_slave_checker

bind wiper_slave wiper_slave_checker u_chk (.clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_upper(address_strap_upper),
    .address_strap_lower(address_strap_lower), .tap_select(tap_select),
    .wiper_at_low_terminal(wiper_at_low_terminal), .wiper_at_high_terminal(wiper_at_high_terminal));

// file: bus_master_model.sv
/* Behavioural two-wire bus master, 800 ns bit period.
   Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/1ps
module bus_master_model
(
    // Bus pins seen from the master
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    // Clock idles high and stands still between frames
    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    // One bit: data set in the low phase, sampled mid high phase
    task automatic put_bit(input logic b, output logic got);
        sda_pull = !b;
        #300 scl = 1'b1;
        #150 got = sda_line;
        #150 scl = 1'b0;
        #200;
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_pull = 1'b0;
        #300 scl = 1'b1;
        #400 sda_pull = 1'b1;
        #400 scl = 1'b0;
        #200;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #300 scl = 1'b1;
        #400 sda_pull = 1'b0;
        #400;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(b[i], g);
        put_bit(1'b1, g);
        ack = !g;
    endtask
    // Last byte: master answers with a release
    task automatic recv(input logic more, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
        put_bit(!more, g);
    endtask
endmodule // bus_master_model

// file: testbench.sv
/* Self-checking bench for the wiper slave.
   Assumes the master model and checker are compiled before it. */
`timescale 1ns/1ps
`include "wiper_defs.svh"
module testbench;
    import wiper_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk, reset, scl, m_pull, sda_out, sda_oe, lo_t, hi_t, oe_seen;
    logic [1:0] straps;     // Upper, lower strap levels
    logic [7:0] tap, rd;    // Tap output, read data
    int         n_errors, total_checks;
    wire logic  sda_line = !(m_pull || sda_oe); // Pull-up wire
    wiper_slave DUT (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .address_strap_upper(straps[1]), .address_strap_lower(straps[0]),
        .tap_select(tap), .wiper_at_low_terminal(lo_t), .wiper_at_high_terminal(hi_t));
    bus_master_model bm (.scl(scl), .sda_pull(m_pull), .sda_line(sda_line));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Records any pull-down while a foreign address is on the bus
    always @(posedge clk) if (sda_oe === 1'b1) oe_seen <= 1'b1;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
            n_errors++;
        end
    endtask
    task automatic write_reg(input logic [1:0] s, input logic [7:0] ra, input logic [7:0] d, input logic ok);
        logic a1, a2, a3;
        @(posedge clk);
        #1 bm.start();
        bm.send({`ID_UPPER_BITS, s, 1'b0}, a1);
        bm.send(ra, a2);
        bm.send(d, a3);
        bm.stop();
        check({5'h0, a1, a2, a3}, ok ? 8'h07 : 8'h00, "write acks");
    endtask
    task automatic read_reg(input logic [7:0] ra, output logic [7:0] d);
        logic a1, a2, a3;
        @(posedge clk);
        #1 bm.start();
        bm.send({`ID_UPPER_BITS, straps, 1'b0}, a1);
        bm.send(ra, a2);
        bm.start();
        bm.send({`ID_UPPER_BITS, straps, 1'b1}, a3);
        bm.recv(1'b0, d);
        bm.stop();
        check({5'h0, a1, a2, a3}, 8'h07, "read acks");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(tap, `WIPER_RESET_VAL, "reset tap");
        check({6'h0, lo_t, hi_t}, 8'h00, "reset end flags");
        $display("t_reset done");
    endtask
    task automatic t_ends();
        logic [7:0] v [2] = '{8'h00, 8'hFF};
        for (int i = 0; i < 2; i++)
        begin
            write_reg(straps, `WIPER_REG_ADDR, v[i], 1'b1);
            check(tap, v[i], "end tap");
            check({6'h0, lo_t, hi_t}, (i == 0) ? 8'h02 : 8'h01, "end flags");
        end
        $display("t_ends done");
    endtask
    task automatic t_readback();
        write_reg(straps, `WIPER_REG_ADDR, 8'h5A, 1'b1);
        read_reg(`WIPER_REG_ADDR, rd);
        check(rd, 8'h5A, "wiper readback");
        write_reg(straps, `CONTROL_REG_ADDR, 8'h3C, 1'b1);
        check(tap, 8'h5A, "tap after other register");
        read_reg(`CONTROL_REG_ADDR, rd);
        check(rd, 8'h3C, "second register readback");
        $display("t_readback done");
    endtask
    task automatic t_straps();
        for (int s = 0; s < 4; s++)
        begin
            straps = 2'(s);
            repeat (6) @(posedge clk);
            oe_seen = 1'b0;
            write_reg(~straps, `WIPER_REG_ADDR, 8'hC3, 1'b0);
            check({7'h0, oe_seen}, 8'h00, "line quiet for others");
            check(tap, (s == 0) ? 8'h5A : 8'h1F + 8'(s), "foreign write ignored");
            write_reg(straps, `WIPER_REG_ADDR, 8'h20 + 8'(s), 1'b1);
            check(tap, 8'h20 + 8'(s), "own address write");
        end
        $display("t_straps done");
    endtask
    // Unmapped write is acked but dropped; master ack repeats the same register
    task automatic t_burst();
        logic       a1, a2, a3;
        logic [7:0] b0, b1;
        write_reg(straps, 8'h05, 8'h77, 1'b1);
        check(tap, 8'h23, "unmapped write dropped");
        @(posedge clk);
        #1 bm.start();
        bm.send({`ID_UPPER_BITS, straps, 1'b0}, a1);
        bm.send(`WIPER_REG_ADDR, a2);
        bm.start();
        bm.send({`ID_UPPER_BITS, straps, 1'b1}, a3);
        bm.recv(1'b1, b0);
        bm.recv(1'b0, b1);
        bm.stop();
        check({5'h0, a1, a2, a3}, 8'h07, "burst acks");
        check(b0, 8'h23, "burst first byte");
        check(b1, 8'h23, "burst second byte");
        $display("t_burst done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        straps = 2'b00;
        oe_seen = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        repeat (6) @(posedge clk);
        t_reset();
        t_ends();
        t_readback();
        t_straps();
        t_burst();
        give_verdict();
    end
    // Whole run needs about 0.42 ms of bus traffic
    initial
    begin
        #2_000_000;
        n_errors++;
        give_verdict();
    end
endmodule // testbench
